// >>> dma_bus_consts.svh
// Named constants of the DMA bus handshake and reset block.
// Assumes it is included by bare name and defines nothing else.
`ifndef DMA_BUS_CONSTS_SVH
`define DMA_BUS_CONSTS_SVH

`define CMD_STOP_BIT        0
`define CMD_START_BIT       1
`define CMD_RESET_VALUE     8'h01
`define IMR_RESET_VALUE     8'h00
`define DCR_RESET_VALUE     8'h00
`define TCR_RESET_VALUE     8'h00
`define SEL_COMMAND         2'h0
`define SEL_INTR_MASK       2'h1
`define SEL_DATA_CFG        2'h2
`define SEL_TX_CFG          2'h3
`define RESET_LIMIT_CYCLES  4'hA
`define WORDS_ZERO          4'h0
`define WORDS_ONE           4'h1
`define SYNC_GRANT          0
`define SYNC_RESET_N        1
`define SYNC_RESET_VALUE    2'h0

`endif

// >>> dma_bus_pkg.sv
// Types shared by the DMA bus handshake and reset block.
// Assumes nothing of its surroundings.
package dma_bus_pkg;

    typedef struct packed {
        logic [7:0] command;
        logic [7:0] intr_mask;
        logic [7:0] data_cfg;
        logic [7:0] tx_cfg;
    } settings_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ  = 3'b001,
        ST_T1   = 3'b010,
        ST_T2   = 3'b011,
        ST_T3   = 3'b100,
        ST_T4   = 3'b101
    } dma_state_e;

endpackage : dma_bus_pkg

// >>> pin_sync.sv
// Three-stage synchroniser with a two-stage agreement filter, one per bit.
// Assumes asynchronous pin inputs and a synchronous active-high reset.
`timescale 1ns/100ps
module pin_sync #(
    parameter int         WIDTH   = 2,
    parameter logic [1:0] RST_VAL = 2'h0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Pins and filtered levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            // The first stage feeds only the second, to contain metastability.
            always_ff @(posedge clk) begin
                if (reset) begin
                    s1   <= RST_VAL[i];
                    s2   <= RST_VAL[i];
                    s3   <= RST_VAL[i];
                    q[i] <= RST_VAL[i];
                end else begin
                    s1 <= d[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        q[i] <= s3;
                    end
                end
            end
        end
    endgenerate

endmodule : pin_sync

// >>> dma_bus_handshake_reset.sv
// Bus request and grant handshake for DMA, with the chip reset pin.
// Assumes the bus clock as clk, a pin-level grant and reset, and a
// same-clock FIFO service request from the controller core.
`timescale 1ns/100ps
`include "dma_bus_consts.svh"

// Behaviour
// - Request output high to ask for bus.
// - FIFO service raises request without software.
// - Reset pin low resets at once; the code resets four to five clocks after the pin falls.
// - No network traffic until start bit set.
// - Reset restores command, mask, data, transmit settings.
// - Reset completes within ten bus clocks.
module dma_bus_handshake_reset (
    // Clock and system reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Pins from the bus and board
    input  wire logic                  bus_grant,
    input  wire logic                  chip_reset_n,
    // FIFO demand from the controller core
    input  wire logic                  fifo_service_req,
    input  wire logic [3:0]            burst_words,
    // Settings write port
    input  wire logic                  cfg_write,
    input  wire logic [1:0]            cfg_sel,
    input  wire logic [7:0]            cfg_data,
    // Bus side outputs
    output logic                       bus_request_out,
    output logic                       dma_active,
    output logic                       dma_word_done,
    // Status and settings
    output dma_bus_pkg::settings_s     settings,
    output logic                       start_command_bit,
    output logic                       net_enable,
    output logic                       controller_stopped
);

    logic [1:0]              sync_q;
    logic                    grant_f;
    logic                    chip_rst;
    logic [3:0]              words_left;
    logic                    last_word;
    dma_bus_pkg::dma_state_e state;
    dma_bus_pkg::dma_state_e next_state;
    dma_bus_pkg::settings_s  settings_default;

    assign settings_default = '{command:   `CMD_RESET_VALUE,
                                intr_mask: `IMR_RESET_VALUE,
                                data_cfg:  `DCR_RESET_VALUE,
                                tx_cfg:    `TCR_RESET_VALUE};

    pin_sync #(
        .WIDTH   (2),
        .RST_VAL (`SYNC_RESET_VALUE)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({chip_reset_n, bus_grant}),
        .q     (sync_q)
    );

    assign grant_f   = sync_q[`SYNC_GRANT];
    assign chip_rst  = ~sync_q[`SYNC_RESET_N];
    assign last_word = (state == dma_bus_pkg::ST_T4) && (words_left == `WORDS_ONE);

    always_comb begin
        next_state = state;
        unique case (state)
            dma_bus_pkg::ST_IDLE: begin
                // A grant left over from the last tenure must be seen to fall first.
                // This also makes a grant tied high lock the block out for good.
                if (fifo_service_req && start_command_bit && !grant_f
                        && burst_words != `WORDS_ZERO) begin
                    next_state = dma_bus_pkg::ST_REQ;
                end
            end
            dma_bus_pkg::ST_REQ: begin
                if (grant_f) begin
                    next_state = dma_bus_pkg::ST_T1;
                end
            end
            dma_bus_pkg::ST_T1: begin
                next_state = grant_f ? dma_bus_pkg::ST_T2 : dma_bus_pkg::ST_REQ;
            end
            dma_bus_pkg::ST_T2: begin
                next_state = grant_f ? dma_bus_pkg::ST_T3 : dma_bus_pkg::ST_REQ;
            end
            dma_bus_pkg::ST_T3: begin
                next_state = grant_f ? dma_bus_pkg::ST_T4 : dma_bus_pkg::ST_REQ;
            end
            dma_bus_pkg::ST_T4: begin
                if (last_word) begin
                    next_state = dma_bus_pkg::ST_IDLE;
                end else if (grant_f) begin
                    next_state = dma_bus_pkg::ST_T1;
                end else begin
                    next_state = dma_bus_pkg::ST_REQ;
                end
            end
            default: begin
                next_state = dma_bus_pkg::ST_IDLE;
            end
        endcase
    end

    // The pin passes the synchroniser first, so reset lands four to five
    // clocks after it falls, still inside the ten-clock bound.
    // Immediate reset abort.
    always_ff @(posedge clk) begin
        if (reset || chip_rst) begin
            state <= dma_bus_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // A word interrupted by a lost grant is redone from its first cycle.
    always_ff @(posedge clk) begin
        if (reset || chip_rst) begin
            words_left <= `WORDS_ZERO;
        end else if (state == dma_bus_pkg::ST_IDLE && next_state == dma_bus_pkg::ST_REQ) begin
            words_left <= burst_words;
        end else if (state == dma_bus_pkg::ST_T4) begin
            words_left <= words_left - `WORDS_ONE;
        end
    end

    // The grant is filtered, so a withdrawn grant is honoured up to five
    // clocks late; the bus owner must allow for that before reusing the bus.
    // Request handshake.
    always_ff @(posedge clk) begin
        if (reset || chip_rst) begin
            bus_request_out <= 1'b0;
            dma_active      <= 1'b0;
            dma_word_done   <= 1'b0;
        end else begin
            bus_request_out <= (next_state != dma_bus_pkg::ST_IDLE);
            dma_active      <= (next_state == dma_bus_pkg::ST_T1)
                            || (next_state == dma_bus_pkg::ST_T2)
                            || (next_state == dma_bus_pkg::ST_T3)
                            || (next_state == dma_bus_pkg::ST_T4);
            dma_word_done   <= (state == dma_bus_pkg::ST_T4);
        end
    end

    always_ff @(posedge clk) begin
        if (reset || chip_rst) begin
            settings <= settings_default;
        end else if (cfg_write) begin
            unique case (cfg_sel)
                `SEL_COMMAND:   settings.command   <= cfg_data;
                `SEL_INTR_MASK: settings.intr_mask <= cfg_data;
                `SEL_DATA_CFG:  settings.data_cfg  <= cfg_data;
                `SEL_TX_CFG:    settings.tx_cfg    <= cfg_data;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset || chip_rst) begin
            start_command_bit  <= 1'b0;
            net_enable         <= 1'b0;
            controller_stopped <= 1'b1;
        end else begin
            start_command_bit  <= settings.command[`CMD_START_BIT];
            net_enable         <= settings.command[`CMD_START_BIT]
                               && !settings.command[`CMD_STOP_BIT];
            controller_stopped <= settings.command[`CMD_STOP_BIT]
                               || !settings.command[`CMD_START_BIT];
        end
    end

    // Counts bus clocks the reset pin has been low, for the reset bound check.
    logic [3:0] low_cnt;
    always_ff @(posedge clk) begin
        if (reset || chip_reset_n) begin
            low_cnt <= `WORDS_ZERO;
        end else if (low_cnt != `RESET_LIMIT_CYCLES) begin
            low_cnt <= low_cnt + `WORDS_ONE;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    req_has_demand_a: assert property ($rose(bus_request_out) |-> $past(fifo_service_req))
        else $error("Bus request rose without FIFO demand.");
    req_start_gate_a: assert property ($rose(bus_request_out) |-> $past(start_command_bit))
        else $error("Bus request rose while not started.");
    cycle_granted_a: assert property ($rose(dma_active) |-> $past(grant_f))
        else $error("DMA cycle began without grant.");
    req_fresh_grant_a: assert property ($rose(bus_request_out) |-> !$past(grant_f))
        else $error("Bus request rose while an old grant stood.");
    req_held_a: assert property ($fell(bus_request_out) |-> $past(chip_rst) || $past(last_word))
        else $error("Bus request dropped before transfers ended.");
    active_has_req_a: assert property (dma_active |-> bus_request_out)
        else $error("DMA cycle without bus request.");
    reset_abort_a: assert property (chip_rst |=> !bus_request_out && !dma_active)
        else $error("Reset did not abort the bus handshake.");
    reset_defaults_a: assert property (chip_rst |=> settings == settings_default)
        else $error("Reset did not restore settings.");
    reset_bound_a: assert property (low_cnt == `RESET_LIMIT_CYCLES |-> controller_stopped && settings == settings_default)
        else $error("Reset not complete within ten bus clocks.");
    no_traffic_a: assert property (net_enable |-> start_command_bit && !controller_stopped)
        else $error("Network enabled without start bit.");

    burst_done_c: cover property (last_word ##1 dma_word_done ##1 !bus_request_out);
    grant_lost_c: cover property (state == dma_bus_pkg::ST_T2 && !grant_f);
    reset_in_cycle_c: cover property (dma_active && chip_rst);
    started_c: cover property ($rose(net_enable));
    stale_grant_c: cover property (state == dma_bus_pkg::ST_IDLE && fifo_service_req && grant_f);

endmodule : dma_bus_handshake_reset

// >>> bus_owner.sv
// Bus owner model that grants the local bus to the DMA block.
// Assumes the block's clock and a level request from the block.
`timescale 1ns/100ps
module bus_owner (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Handshake
    input  wire logic       bus_request_out,
    input  wire logic [3:0] grant_delay,
    input  wire logic       preempt,
    output logic            bus_grant
);
    logic [3:0] wait_count;
    logic       grant_q;

    // grant after request.
    // The grant falls with the request, or one clock after it when delayed, so it is never left high.
    always_ff @(posedge clk) begin
        if (reset || !bus_request_out) begin
            wait_count <= 4'h0;
            grant_q    <= 1'b0;
        end else if (grant_delay != 4'h0 && wait_count >= grant_delay) begin
            grant_q <= 1'b1;
        end else begin
            wait_count <= wait_count + 4'h1;
        end
    end

    assign bus_grant = preempt ? 1'b0 : ((grant_delay == 4'h0) ? bus_request_out : grant_q);
endmodule : bus_owner

// >>> tb.sv
// Self-checking bench for the DMA bus handshake and reset block.
// Assumes the design files and the bus owner model are compiled first.
`timescale 1ns/100ps
module tb;
    logic                   clk, reset, bus_grant, chip_reset_n, fifo_service_req, preempt;
    logic                   cfg_write, bus_request_out, dma_active, dma_word_done;
    logic                   start_command_bit, net_enable, controller_stopped;
    logic [3:0]             burst_words, grant_delay;
    logic [1:0]             cfg_sel;
    logic [7:0]             cfg_data;
    dma_bus_pkg::settings_s settings;
    int                     err_count, total_checks;

    dma_bus_handshake_reset DUT (.clk(clk), .reset(reset), .bus_grant(bus_grant),
        .chip_reset_n(chip_reset_n), .fifo_service_req(fifo_service_req),
        .burst_words(burst_words), .cfg_write(cfg_write), .cfg_sel(cfg_sel),
        .cfg_data(cfg_data), .bus_request_out(bus_request_out), .dma_active(dma_active),
        .dma_word_done(dma_word_done), .settings(settings),
        .start_command_bit(start_command_bit), .net_enable(net_enable),
        .controller_stopped(controller_stopped));

    bus_owner owner (.clk(clk), .reset(reset), .bus_request_out(bus_request_out),
        .grant_delay(grant_delay), .preempt(preempt), .bus_grant(bus_grant));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task end_sim;
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    task check_word(input logic [31:0] exp, input logic [31:0] act);
        total_checks++;
        if (act !== exp) begin
            err_count++;
            $display("[FAIL] %0t exp %0h got %0h", $time, exp, act);
        end
    endtask : check_word

    task check_bit(input logic exp, input logic act);
        check_word({31'h0, exp}, {31'h0, act});
    endtask : check_bit

    task write_cfg(input logic [1:0] sel, input logic [7:0] data);
        cfg_write = 1'b1;
        cfg_sel   = sel;
        cfg_data  = data;
        cycles(1);
        cfg_write = 1'b0;
        cycles(1);
    endtask : write_cfg

    // Waits for the request to rise; a missing request ends the run.
    task demand(input logic [3:0] words, input logic [3:0] delay);
        int n;
        grant_delay      = delay;
        burst_words      = words;
        fifo_service_req = 1'b1;
        for (n = 0; n < 8 && bus_request_out !== 1'b1; n++) cycles(1);
        fifo_service_req = 1'b0;
        check_bit(1'b1, bus_request_out);
        if (bus_request_out !== 1'b1) end_sim();
    endtask : demand

    task test_defaults;
        check_word(32'h01000000, settings);
        check_bit(1'b1, controller_stopped);
        check_bit(1'b0, net_enable);
        fifo_service_req = 1'b1;
        burst_words      = 4'h2;
        cycles(8);
        check_bit(1'b0, bus_request_out);
        fifo_service_req = 1'b0;
    endtask : test_defaults

    task test_settings;
        write_cfg(2'h0, 8'h02);
        write_cfg(2'h1, 8'h5A);
        write_cfg(2'h2, 8'h3C);
        write_cfg(2'h3, 8'hA5);
        cycles(2);
        check_word(32'h025A3CA5, settings);
        check_bit(1'b1, start_command_bit);
        check_bit(1'b1, net_enable);
        check_bit(1'b0, controller_stopped);
    endtask : test_settings

    task test_burst(input logic [3:0] words, input logic [3:0] delay);
        int n, done, bad;
        done = 0;
        bad  = 0;
        demand(words, delay);
        for (n = 0; n < 300 && bus_request_out === 1'b1; n++) begin
            if (dma_active === 1'b1 && bus_grant !== 1'b1) bad++;
            cycles(1);
            if (dma_word_done === 1'b1) done++;
        end
        check_word(32'(words), 32'(done));
        check_word(32'h0, 32'(bad));
        check_bit(1'b0, bus_request_out);
        if (n == 300) end_sim();
    endtask : test_burst

    task test_preempt;
        int n, done, drops;
        done  = 0;
        drops = 0;
        demand(4'h2, 4'h0);
        cycles(6);
        preempt = 1'b1;
        for (n = 0; n < 12; n++) begin
            cycles(1);
            if (bus_request_out !== 1'b1) drops++;
            if (dma_word_done === 1'b1) done++;
        end
        check_bit(1'b0, dma_active);
        preempt = 1'b0;
        for (n = 0; n < 300 && bus_request_out === 1'b1; n++) begin
            cycles(1);
            if (dma_word_done === 1'b1) done++;
        end
        check_word(32'h2, 32'(done));
        check_word(32'h0, 32'(drops));
        check_bit(1'b0, bus_request_out);
        if (n == 300) end_sim();
    endtask : test_preempt

    task test_chip_reset;
        demand(4'h3, 4'h0);
        cycles(6);
        chip_reset_n = 1'b0;
        cycles(10);
        check_bit(1'b0, bus_request_out);
        check_bit(1'b0, dma_active);
        check_word(32'h01000000, settings);
        write_cfg(2'h0, 8'h02);
        cycles(2);
        check_word(32'h01000000, settings);
        check_bit(1'b0, net_enable);
        chip_reset_n     = 1'b1;
        cycles(6);
        fifo_service_req = 1'b1;
        cycles(8);
        check_bit(1'b0, bus_request_out);
        fifo_service_req = 1'b0;
    endtask : test_chip_reset

    initial begin
        err_count        = 0;
        total_checks     = 0;
        reset            = 1'b1;
        chip_reset_n     = 1'b1;
        fifo_service_req = 1'b0;
        preempt          = 1'b0;
        burst_words      = 4'h0;
        grant_delay      = 4'h0;
        cfg_write        = 1'b0;
        cfg_sel          = 2'h0;
        cfg_data         = 8'h00;
        cycles(10);
        reset = 1'b0;
        cycles(6);
        test_defaults();
        test_settings();
        test_burst(4'h1, 4'h0);
        test_burst(4'hF, 4'h9);
        test_preempt();
        test_chip_reset();
        end_sim();
    end
endmodule : tb
